/* File: core/ascfg_top.sv */
`timescale 1ns/100ps
// Function
// - Reset restores the capability and configuration register defaults.
// - Bits 0-3 read the highest supported baud code, fixed at 115200.
// - Bits 4-7 hold the writable current baud code, default 9600.
// - Every baud code up to the reported maximum works; higher codes are refused.
// - Bit 8 set enters text mode, cleared returns to binary packets.
// - Without text mode support, enabling it answers with an execution error.
// - The reply to a mode write goes out in the old format first.
// - Select rise clears input; with bit 12 low it also resets baud.
// - The select rise action only works while the serial interface is selected.
// - Text replies give error flag, status, register, data, then CR LF.
// - Text mode falls back to binary on a config write or control character.
// - The control character that ends text mode starts the next binary packet.
// - Text mode commands skip the checksum test.
// - Four carriage returns in binary mode write 0x0D0D to register 0x0D.
// - Binary packets are 32 bits sent as four bytes, high byte first.
// - Characters are 8 data bits, no parity, one stop bit, LSB first.
module ascfg_top #(
  parameter int unsigned CLK_HZ          = ascfg_pkg::CLK_HZ,
  parameter bit          ASCII_SUPPORTED = 1'b1
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Serial pins
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        module_select_n_i,
  output logic             irdy_n_o,
  // Interface choice from strap logic
  input  wire logic        serial_if_selected_i,
  // Commands toward the transport layer
  output logic             cmd_valid_o,
  input  wire logic        cmd_ready_i,
  output logic [31:0]      cmd_data_o,
  // Responses from the transport layer
  input  wire logic        resp_valid_i,
  output logic             resp_ready_o,
  input  wire logic [31:0] resp_data_i,
  // Configuration state
  output logic [15:0]      iocap_o,
  output logic             ascii_mode_o
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ascfg_rx_t;

  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic        ms_s1;
    logic        ms_s2;
    logic        ms_s3;
    ascfg_rx_t   rx_st;
    logic [14:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [1:0]  pk_cnt;
    logic [31:0] pk;
    logic        pk_vld;
    logic        pk_txt;
    logic [1:0]  a_fld;
    logic        a_wr;
    logic [7:0]  a_reg;
    logic [15:0] a_dat;
    logic [3:0]  cfg_baud;
    logic        cfg_ascii;
    logic        cfg_rms;
    logic [3:0]  pd_baud;
    logic        pd_ascii;
    logic        pd_rms;
    logic        pd_apply;
    logic        wait_resp;
    logic        rp_vld;
    logic        rp_done;
    logic        rp_txt;
    logic        rp_ce;
    logic [1:0]  rp_st;
    logic [7:0]  rp_reg;
    logic [15:0] rp_dat;
    logic [4:0]  rp_idx;
    logic        tx_busy;
    logic [14:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic        tx_line;
  } ascfg_st_t;

  ascfg_st_t st_ff;
  ascfg_st_t nxt_st;
  logic      fwd_valid;
  logic      buf_flush;

  ascfg_stream_if cmd_in ();
  ascfg_stream_if cmd_out ();

  function automatic logic [14:0] baud_div(input logic [3:0] code);
    int unsigned d;
    case (code)
      ascfg_pkg::BAUD_CODE_19200:  d = CLK_HZ / ascfg_pkg::BAUD_19200;
      ascfg_pkg::BAUD_CODE_38400:  d = CLK_HZ / ascfg_pkg::BAUD_38400;
      ascfg_pkg::BAUD_CODE_57600:  d = CLK_HZ / ascfg_pkg::BAUD_57600;
      ascfg_pkg::BAUD_CODE_115200: d = CLK_HZ / ascfg_pkg::BAUD_115200;
      default:                     d = CLK_HZ / ascfg_pkg::BAUD_9600;
    endcase
    return d[14:0];
  endfunction

  function automatic logic [15:0] iocap_of(input logic [3:0] baud, input logic ascii, input logic select_rise_action);
    logic [15:0] v;
    v = '0;
    v[ascfg_pkg::IOCAP_MAX_LSB +: 4]  = ascfg_pkg::MAX_BAUD_CODE;
    v[ascfg_pkg::IOCAP_BAUD_LSB +: 4] = baud;
    v[ascfg_pkg::IOCAP_ASCII_BIT]     = ascii;
    v[ascfg_pkg::IOCAP_RMS_BIT]       = select_rise_action;
    return v;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Returns a valid flag above the nibble value
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      return {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction

  // Text reply layout: "CE=c Status=s 0xRR 0xDDDD" CR LF
  function automatic logic [7:0] reply_chr(input logic [4:0] idx, input logic ce, input logic [1:0] stat,
                                           input logic [7:0] rg, input logic [15:0] dat);
    case (idx)
      5'h00:   return 8'h43;
      5'h01:   return 8'h45;
      5'h02:   return 8'h3D;
      5'h03:   return ce ? 8'h31 : 8'h30;
      5'h05:   return 8'h53;
      5'h06:   return 8'h74;
      5'h07:   return 8'h61;
      5'h08:   return 8'h74;
      5'h09:   return 8'h75;
      5'h0A:   return 8'h73;
      5'h0B:   return 8'h3D;
      5'h0C:   return 8'h30 + {6'h00, stat};
      5'h0E:   return 8'h30;
      5'h0F:   return 8'h78;
      5'h10:   return hex_chr(rg[7:4]);
      5'h11:   return hex_chr(rg[3:0]);
      5'h13:   return 8'h30;
      5'h14:   return 8'h78;
      5'h15:   return hex_chr(dat[15:12]);
      5'h16:   return hex_chr(dat[11:8]);
      5'h17:   return hex_chr(dat[7:4]);
      5'h18:   return hex_chr(dat[3:0]);
      5'h19:   return ascfg_pkg::CHR_CR;
      5'h1A:   return ascfg_pkg::CHR_LF;
      default: return ascfg_pkg::CHR_SP;
    endcase
  endfunction

  always_comb begin
    logic [14:0] div;
    logic        ms_rise;
    logic        byte_vld;
    logic [7:0]  rx_byte;
    logic [4:0]  hv;
    logic [3:0]  bip;
    logic [7:0]  ch;
    logic        last;
    div       = baud_div(st_ff.cfg_baud);
    ms_rise   = st_ff.ms_s2 & ~st_ff.ms_s3;
    byte_vld  = 1'b0;
    rx_byte   = st_ff.rx_sh;
    hv        = 5'h00;
    bip       = 4'h0;
    ch        = 8'h00;
    last      = 1'b0;
    fwd_valid = 1'b0;
    buf_flush = 1'b0;
    nxt_st    = st_ff;

    nxt_st.rx_s1 = rxd_i;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.ms_s1 = module_select_n_i;
    nxt_st.ms_s2 = st_ff.ms_s1;
    nxt_st.ms_s3 = st_ff.ms_s2;

    // Receiver: start edge, half bit to centre, then one sample per bit
    unique case (st_ff.rx_st)
      RX_IDLE: begin
        if (!st_ff.rx_s2) begin
          nxt_st.rx_st  = RX_START;
          nxt_st.rx_cnt = {1'b0, div[14:1]};
        end
      end
      RX_START: begin
        if (st_ff.rx_cnt != 15'h0000) begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 15'h0001;
        end else begin
          nxt_st.rx_st  = st_ff.rx_s2 ? RX_IDLE : RX_DATA;
          nxt_st.rx_cnt = div - 15'h0001;
          nxt_st.rx_bit = 3'h0;
        end
      end
      RX_DATA: begin
        if (st_ff.rx_cnt != 15'h0000) begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 15'h0001;
        end else begin
          nxt_st.rx_sh  = {st_ff.rx_s2, st_ff.rx_sh[7:1]};
          nxt_st.rx_cnt = div - 15'h0001;
          nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
          if (st_ff.rx_bit == 3'h7) begin
            nxt_st.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (st_ff.rx_cnt != 15'h0000) begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 15'h0001;
        end else begin
          // A missing stop bit drops the character
          nxt_st.rx_st = RX_IDLE;
          byte_vld     = st_ff.rx_s2;
        end
      end
    endcase

    // Bytes arriving while a packet waits are lost; the host paces on busy
    if (byte_vld && !st_ff.pk_vld) begin
      if (st_ff.cfg_ascii) begin
        hv = hex_val(rx_byte);
        if (rx_byte == ascfg_pkg::CHR_CR) begin
          nxt_st.pk     = {7'h00, st_ff.a_wr, st_ff.a_reg, st_ff.a_dat};
          nxt_st.pk_vld = 1'b1;
          nxt_st.pk_txt = 1'b1;
          nxt_st.a_fld  = 2'h0;
          nxt_st.a_reg  = 8'h00;
          nxt_st.a_dat  = 16'h0000;
        end else if (rx_byte < ascfg_pkg::CHR_SP || rx_byte == ascfg_pkg::CHR_DEL) begin
          nxt_st.cfg_ascii = 1'b0;
          nxt_st.pk        = {24'h00_0000, rx_byte};
          nxt_st.pk_cnt    = 2'h1;
          nxt_st.a_fld     = 2'h0;
          nxt_st.a_reg     = 8'h00;
          nxt_st.a_dat     = 16'h0000;
        end else if (hv[4] && st_ff.a_fld == 2'h1) begin
          nxt_st.a_reg = {st_ff.a_reg[3:0], hv[3:0]};
        end else if (hv[4] && st_ff.a_fld == 2'h2) begin
          nxt_st.a_dat = {st_ff.a_dat[11:0], hv[3:0]};
        end else if (rx_byte == 8'h78 || rx_byte == 8'h58) begin
          // The 0x prefix restarts the field so the leading zero is harmless
          if (st_ff.a_fld == 2'h1) begin
            nxt_st.a_reg = 8'h00;
          end else begin
            nxt_st.a_dat = 16'h0000;
          end
        end else if (rx_byte == ascfg_pkg::CHR_SP) begin
          if (st_ff.a_fld != 2'h2) begin
            nxt_st.a_fld = st_ff.a_fld + 2'h1;
          end
        end else if (st_ff.a_fld == 2'h0 && (rx_byte == 8'h52 || rx_byte == 8'h72)) begin
          nxt_st.a_wr = 1'b0;
        end else if (st_ff.a_fld == 2'h0 && (rx_byte == 8'h57 || rx_byte == 8'h77)) begin
          nxt_st.a_wr = 1'b1;
        end
      end else begin
        nxt_st.pk     = {st_ff.pk[23:0], rx_byte};
        nxt_st.pk_cnt = st_ff.pk_cnt + 2'h1;
        if (st_ff.pk_cnt == ascfg_pkg::PKT_LAST) begin
          nxt_st.pk_vld = 1'b1;
          nxt_st.pk_txt = 1'b0;
        end
      end
    end

    // Packet dispatch: checksum errors and configuration register locally, the rest to the buffer
    for (int i = 0; i < 8; i++) begin
      bip = bip ^ st_ff.pk[4*i +: 4];
    end
    if (st_ff.pk_vld && !st_ff.rp_vld && !st_ff.rp_done && !st_ff.wait_resp) begin
      if (!st_ff.pk_txt && bip != 4'h0) begin
        nxt_st.pk_vld = 1'b0;
        nxt_st.rp_vld = 1'b1;
        nxt_st.rp_ce  = 1'b1;
        nxt_st.rp_st  = ascfg_pkg::STATUS_OK;
        nxt_st.rp_reg = st_ff.pk[23:16];
        nxt_st.rp_dat = st_ff.pk[15:0];
      end else if (st_ff.pk[23:16] == ascfg_pkg::IOCAP_REG) begin
        nxt_st.pk_vld = 1'b0;
        nxt_st.rp_vld = 1'b1;
        nxt_st.rp_ce  = 1'b0;
        nxt_st.rp_st  = ascfg_pkg::STATUS_OK;
        nxt_st.rp_reg = ascfg_pkg::IOCAP_REG;
        nxt_st.rp_dat = iocap_of(st_ff.cfg_baud, st_ff.cfg_ascii, st_ff.cfg_rms);
        if (st_ff.pk[ascfg_pkg::PKT_WR_BIT]) begin
          if ((st_ff.pk[ascfg_pkg::IOCAP_ASCII_BIT] && !ASCII_SUPPORTED) ||
              st_ff.pk[ascfg_pkg::IOCAP_BAUD_LSB +: 4] > ascfg_pkg::MAX_BAUD_CODE) begin
            nxt_st.rp_st = ascfg_pkg::STATUS_XE;
          end else begin
            // Only writable fields are taken; the rest of the word is dropped
            nxt_st.pd_baud  = st_ff.pk[ascfg_pkg::IOCAP_BAUD_LSB +: 4];
            nxt_st.pd_ascii = st_ff.pk[ascfg_pkg::IOCAP_ASCII_BIT];
            nxt_st.pd_rms   = st_ff.pk[ascfg_pkg::IOCAP_RMS_BIT];
            nxt_st.pd_apply = 1'b1;
            nxt_st.rp_dat   = iocap_of(st_ff.pk[ascfg_pkg::IOCAP_BAUD_LSB +: 4],
                                       st_ff.pk[ascfg_pkg::IOCAP_ASCII_BIT],
                                       st_ff.pk[ascfg_pkg::IOCAP_RMS_BIT]);
          end
        end
      end else begin
        fwd_valid = 1'b1;
        if (cmd_in.ready) begin
          nxt_st.pk_vld    = 1'b0;
          nxt_st.wait_resp = 1'b1;
        end
      end
      nxt_st.rp_txt = st_ff.cfg_ascii;
      nxt_st.rp_idx = 5'h00;
    end

    if (resp_valid_i && resp_ready_o) begin
      nxt_st.wait_resp = 1'b0;
      nxt_st.rp_vld    = 1'b1;
      nxt_st.rp_txt    = st_ff.cfg_ascii;
      nxt_st.rp_ce     = resp_data_i[ascfg_pkg::PKT_CE_BIT];
      nxt_st.rp_st     = resp_data_i[ascfg_pkg::PKT_ST_LSB +: 2];
      nxt_st.rp_reg    = resp_data_i[23:16];
      nxt_st.rp_dat    = resp_data_i[15:0];
      nxt_st.rp_idx    = 5'h00;
    end

    // Transmitter: ten bit frame, start bit first, LSB first
    if (st_ff.tx_busy) begin
      if (st_ff.tx_cnt != 15'h0000) begin
        nxt_st.tx_cnt = st_ff.tx_cnt - 15'h0001;
      end else if (st_ff.tx_bit == 4'h9) begin
        nxt_st.tx_busy = 1'b0;
      end else begin
        nxt_st.tx_sh   = {1'b1, st_ff.tx_sh[9:1]};
        nxt_st.tx_line = st_ff.tx_sh[1];
        nxt_st.tx_bit  = st_ff.tx_bit + 4'h1;
        nxt_st.tx_cnt  = div - 15'h0001;
      end
    end else if (st_ff.rp_vld) begin
      if (st_ff.rp_txt) begin
        ch   = reply_chr(st_ff.rp_idx, st_ff.rp_ce, st_ff.rp_st, st_ff.rp_reg, st_ff.rp_dat);
        last = (st_ff.rp_idx == ascfg_pkg::TXT_LAST);
      end else begin
        unique case (st_ff.rp_idx[1:0])
          2'h0: ch = {5'h00, st_ff.rp_ce, st_ff.rp_st};
          2'h1: ch = st_ff.rp_reg;
          2'h2: ch = st_ff.rp_dat[15:8];
          2'h3: ch = st_ff.rp_dat[7:0];
        endcase
        last = (st_ff.rp_idx[1:0] == ascfg_pkg::PKT_LAST);
      end
      nxt_st.tx_sh   = {1'b1, ch, 1'b0};
      nxt_st.tx_line = 1'b0;
      nxt_st.tx_busy = 1'b1;
      nxt_st.tx_bit  = 4'h0;
      nxt_st.tx_cnt  = div - 15'h0001;
      nxt_st.rp_idx  = st_ff.rp_idx + 5'h01;
      nxt_st.rp_vld  = ~last;
      nxt_st.rp_done = last;
    end

    // New settings wait until the last reply bit has left the pin
    if (st_ff.rp_done && !st_ff.tx_busy) begin
      nxt_st.rp_done = 1'b0;
      if (st_ff.pd_apply) begin
        nxt_st.pd_apply  = 1'b0;
        nxt_st.cfg_baud  = st_ff.pd_baud;
        nxt_st.cfg_ascii = st_ff.pd_ascii;
        nxt_st.cfg_rms   = st_ff.pd_rms;
      end
    end

    // Select rise clears packet assembly and the command buffer, not the receiver; the action bit decides on baud
    if (ms_rise && serial_if_selected_i) begin
      buf_flush     = 1'b1;
      nxt_st.pk_vld = 1'b0;
      nxt_st.pk_cnt = 2'h0;
      nxt_st.a_fld  = 2'h0;
      nxt_st.a_reg  = 8'h00;
      nxt_st.a_dat  = 16'h0000;
      if (!st_ff.cfg_rms) begin
        nxt_st.cfg_baud = ascfg_pkg::BAUD_RST;
        nxt_st.pd_baud  = ascfg_pkg::BAUD_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff           <= '0;
      st_ff.rx_s1     <= 1'b1;
      st_ff.rx_s2     <= 1'b1;
      st_ff.ms_s1     <= 1'b1;
      st_ff.ms_s2     <= 1'b1;
      st_ff.ms_s3     <= 1'b1;
      st_ff.tx_line   <= 1'b1;
      st_ff.cfg_baud  <= ascfg_pkg::BAUD_RST;
      st_ff.cfg_ascii <= ascfg_pkg::ASCII_RST;
      st_ff.cfg_rms   <= ascfg_pkg::RMS_RST;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign cmd_in.valid = fwd_valid;
  assign cmd_in.data  = st_ff.pk;

  ascfg_buf u_cmd_buf (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .flush_i (buf_flush),
    .in_s    (cmd_in.snk),
    .out_s   (cmd_out.src)
  );

  assign cmd_valid_o   = cmd_out.valid;
  assign cmd_data_o    = cmd_out.data;
  assign cmd_out.ready = cmd_ready_i;
  assign resp_ready_o  = st_ff.wait_resp & ~st_ff.rp_vld & ~st_ff.rp_done;
  assign txd_o         = st_ff.tx_line;
  assign irdy_n_o      = st_ff.pk_vld | st_ff.wait_resp | st_ff.rp_vld | st_ff.rp_done;
  assign iocap_o       = iocap_of(st_ff.cfg_baud, st_ff.cfg_ascii, st_ff.cfg_rms);
  assign ascii_mode_o  = st_ff.cfg_ascii;

  AST_RESET_DEFAULT: assert property (
    @(posedge clk_i) !rst_n_i |=> iocap_o == ascfg_pkg::IOCAP_RST)
    else $error("Configuration register not at default after reset");
  AST_MAX_RATE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) iocap_o[3:0] == ascfg_pkg::MAX_BAUD_CODE)
    else $error("Maximum baud field changed");
  AST_BAUD_RANGE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) st_ff.cfg_baud <= ascfg_pkg::MAX_BAUD_CODE)
    else $error("Baud code above supported maximum");
  AST_MODE_AFTER_REPLY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(st_ff.cfg_ascii) |-> $past(st_ff.rp_done) && !$past(st_ff.tx_busy))
    else $error("Text mode entered before reply finished");
  AST_SELECT_BAUD: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_ff.ms_s2 && !st_ff.ms_s3 && serial_if_selected_i && !st_ff.cfg_rms |=> st_ff.cfg_baud == 4'h0)
    else $error("Select rise did not reset baud code");
  AST_SELECT_IGNORED: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_ff.ms_s2 && !st_ff.ms_s3 && !serial_if_selected_i && !st_ff.rp_done |=> $stable(st_ff.cfg_baud))
    else $error("Select rise acted while serial interface not selected");
  AST_REPLY_CR: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_ff.rp_vld && st_ff.rp_txt && !st_ff.tx_busy && st_ff.rp_idx == ascfg_pkg::TXT_CR_IDX
    |=> st_ff.tx_sh[8:1] == ascfg_pkg::CHR_CR ##1 st_ff.tx_busy)
    else $error("Text reply line end missing");
  AST_CTRL_EXIT: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_ff.rx_st == RX_STOP && st_ff.rx_cnt == 15'h0000 && st_ff.rx_s2 && st_ff.cfg_ascii && !st_ff.pk_vld
    && st_ff.rx_sh < ascfg_pkg::CHR_SP && st_ff.rx_sh != ascfg_pkg::CHR_CR && !st_ff.rp_done && !st_ff.ms_s3
    |=> !st_ff.cfg_ascii && st_ff.pk_cnt == 2'h1 && st_ff.pk[7:0] == $past(st_ff.rx_sh))
    else $error("Control character did not restart binary packet");
  AST_START_BIT: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(st_ff.tx_busy) |-> !txd_o [*2])
    else $error("Frame did not begin with start bit");
  AST_RESERVED_ZERO: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) iocap_o[15:13] == 3'h0 && iocap_o[11:9] == 3'h0)
    else $error("Reserved configuration bits not zero");

endmodule // ascfg_top

/* File: pkg/ascfg_pkg.sv */
package ascfg_pkg;

  // Timing base
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned BAUD_9600   = 9600;
  localparam int unsigned BAUD_19200  = 19200;
  localparam int unsigned BAUD_38400  = 38400;
  localparam int unsigned BAUD_57600  = 57600;
  localparam int unsigned BAUD_115200 = 115200;

  // Baud rate codes
  localparam logic [3:0] BAUD_CODE_9600   = 4'h0;
  localparam logic [3:0] BAUD_CODE_19200  = 4'h1;
  localparam logic [3:0] BAUD_CODE_38400  = 4'h2;
  localparam logic [3:0] BAUD_CODE_57600  = 4'h3;
  localparam logic [3:0] BAUD_CODE_115200 = 4'h4;
  localparam logic [3:0] MAX_BAUD_CODE    = BAUD_CODE_115200;

  // Capability and configuration register
  localparam logic [7:0]  IOCAP_REG       = 8'h0D;
  localparam int unsigned IOCAP_MAX_LSB   = 0;
  localparam int unsigned IOCAP_BAUD_LSB  = 4;
  localparam int unsigned IOCAP_ASCII_BIT = 8;
  localparam int unsigned IOCAP_RMS_BIT   = 12;
  localparam logic [3:0]  BAUD_RST        = BAUD_CODE_9600;
  localparam logic        ASCII_RST       = 1'b0;
  localparam logic        RMS_RST         = 1'b0;
  localparam logic [15:0] IOCAP_RST       = 16'h0004;

  // Packet layout, most significant byte first on the line
  localparam int unsigned PKT_WR_BIT = 24;
  localparam int unsigned PKT_ST_LSB = 24;
  localparam int unsigned PKT_CE_BIT = 26;
  localparam logic [1:0]  PKT_LAST   = 2'h3;

  // Status codes
  localparam logic [1:0] STATUS_OK = 2'h0;
  localparam logic [1:0] STATUS_XE = 2'h1;

  // Text mode characters
  localparam logic [7:0] CHR_CR  = 8'h0D;
  localparam logic [7:0] CHR_LF  = 8'h0A;
  localparam logic [7:0] CHR_SP  = 8'h20;
  localparam logic [7:0] CHR_DEL = 8'h7F;
  localparam logic [4:0] TXT_CR_IDX = 5'h19;
  localparam logic [4:0] TXT_LAST   = 5'h1A;

endpackage

/* File: pkg/ascfg_stream_if.sv */
`timescale 1ns/100ps
interface ascfg_stream_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: core/ascfg_buf.sv */
`timescale 1ns/100ps
module ascfg_buf (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Control
  input  wire logic flush_i,
  // Streams
  ascfg_stream_if.snk in_s,
  ascfg_stream_if.src out_s
);

  typedef struct packed {
    logic [1:0][31:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
  } ascfg_buf_st_t;

  ascfg_buf_st_t st_ff;
  ascfg_buf_st_t nxt_st;
  logic          push;
  logic          pop;

  assign in_s.ready  = (st_ff.cnt != 2'h2);
  assign out_s.valid = (st_ff.cnt != 2'h0);
  assign out_s.data  = st_ff.mem[st_ff.rp];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_s.data;
      nxt_st.wp            = ~st_ff.wp;
    end
    if (pop) begin
      nxt_st.rp = ~st_ff.rp;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    // A flush drops whatever the receiver has not yet taken
    if (flush_i) begin
      nxt_st.wp  = 1'b0;
      nxt_st.rp  = 1'b0;
      nxt_st.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

endmodule // ascfg_buf

/* File: testbench/ascfg_host.sv */
`timescale 1ns/100ps
module ascfg_host (
  // Serial link
  input  wire logic clk_i,
  output logic      rxd_o,
  input  wire logic txd_i
);
  int div = 120;
  initial rxd_o = 1'b1;
  // Start bit, eight bits LSB first, one stop bit
  task automatic tx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i) rxd_o <= f[i];
      repeat (div - 1) @(posedge clk_i);
    end
  endtask
  // Samples each bit at its middle; returns at mid stop bit
  task automatic rx(output logic [7:0] b);
    @(negedge txd_i);
    repeat (div + div / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd_i;
      repeat (div) @(posedge clk_i);
    end
  endtask
endmodule // ascfg_host

/* File: testbench/ascfg_top_tb.sv */
`timescale 1ns/100ps
module ascfg_top_tb;
  logic        clk_i = 0, rst_n_i = 0, ms_n = 0, sel = 1, crdy = 0, rvld = 0;
  logic [31:0] rdat = 32'h0000_0000;
  wire         txd, rxd, cvld, rrdy, asc, irdy;
  wire  [31:0] cdat;
  wire  [15:0] iocap;
  int          n_mismatch = 0, n_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  ascfg_host host (.clk_i(clk_i), .rxd_o(rxd), .txd_i(txd));
  // Short bit time: 10 cycles at 115200, 120 at 9600
  ascfg_top #(.CLK_HZ(1_152_000)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .rxd_i(rxd), .txd_o(txd),
    .module_select_n_i(ms_n), .irdy_n_o(irdy), .serial_if_selected_i(sel), .cmd_valid_o(cvld), .cmd_ready_i(crdy),
    .cmd_data_o(cdat), .resp_valid_i(rvld), .resp_ready_o(rrdy), .resp_data_i(rdat), .iocap_o(iocap),
    .ascii_mode_o(asc));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] mk(input logic wr, input logic [7:0] rg, input logic [15:0] d);
    logic [31:0] p;
    p = {7'h00, wr, rg, d};
    for (int i = 0; i < 7; i++) p[31:28] ^= p[i*4 +: 4];
    return p;
  endfunction
  // Waits out the previous stop bit so the device is idle again
  task automatic pkt(input logic [31:0] p, input logic [31:0] e);
    logic [31:0] r;
    repeat (host.div) @(posedge clk_i);
    fork
      for (int i = 3; i >= 0; i--) host.tx(p[i*8 +: 8]);
      for (int i = 3; i >= 0; i--) host.rx(r[i*8 +: 8]);
    join
    chk("reply", e, r);
  endtask
  // Deferred settings land only once the device reports idle again
  task automatic idle;
    for (int i = 0; i < 2000 && irdy !== 1'b0; i++) @(posedge clk_i);
    chk("irdy", 32'h0000_0000, {31'h0, irdy});
  endtask
  // Text read of the configuration register; text carries no checksum
  task automatic txt_rd;
    string      q = "R 0x0D 0x0000\r";
    string      a = "CE=0 Status=0 0x0D 0x0144\r\n";
    logic [7:0] c;
    repeat (host.div) @(posedge clk_i);
    fork
      for (int i = 0; i < q.len(); i++) host.tx(q[i]);
      for (int i = 0; i < a.len(); i++) begin
        host.rx(c);
        chk("text", {24'h00_0000, 8'(a[i])}, {24'h00_0000, c});
      end
    join
  endtask
  task automatic ms;
    @(posedge clk_i) ms_n <= 1;
    repeat (4) @(posedge clk_i);
    ms_n <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic fwd;
    for (int i = 0; i < 9999 && cvld !== 1'b1; i++) @(posedge clk_i);
    repeat (5) @(posedge clk_i);
    chk("cmd", mk(0, 8'h20, 16'h0000), cdat);
    crdy <= 1;
    @(posedge clk_i) crdy <= 0;
    for (int i = 0; i < 99 && rrdy !== 1'b1; i++) @(posedge clk_i);
    rvld <= 1;
    rdat <= 32'h0020_ABCD;
    @(posedge clk_i) rvld <= 0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    chk("iocap", {16'h0000, iocap}, 32'h0000_0004);
    pkt(mk(1, 8'h0D, 16'h0055), 32'h010D_0004);
    pkt(mk(1, 8'h0D, 16'hE24F), 32'h000D_0044);
    idle;
    host.div = 10;
    sel <= 0;
    ms;
    chk("iocap", {16'h0000, iocap}, 32'h0000_0044);
    sel <= 1;
    ms;
    chk("iocap", {16'h0000, iocap}, 32'h0000_0004);
    host.div = 120;
    pkt(mk(1, 8'h0D, 16'h1044), 32'h000D_1044);
    idle;
    host.div = 10;
    ms;
    chk("iocap", {16'h0000, iocap}, 32'h0000_1044);
    pkt(32'h0D0D_0D0D, 32'h000D_0104);
    chk("ascii", 32'h0000_0000, {31'h0, asc});
    idle;
    host.div = 120;
    chk("ascii", 32'h0000_0001, {31'h0, asc});
    // Leading 0x00 is a control character in text mode
    pkt(32'h000D_000D, 32'h000D_0004);
    chk("ascii", 32'h0000_0000, {31'h0, asc});
    fork
      pkt(mk(0, 8'h20, 16'h0000), 32'h0020_ABCD);
      fwd;
    join
    pkt(mk(1, 8'h0D, 16'h0144), 32'h000D_0144);
    idle;
    host.div = 10;
    chk("ascii", 32'h0000_0001, {31'h0, asc});
    txt_rd;
    give_verdict;
  end
endmodule // ascfg_top_tb
